//--- eem_pkg.sv
// Package for the encoder emulation output block.
// Assumes a 100 MHz system clock and an unsigned rotor angle word.
package eem_pkg;
  // =========================================================
  // Angle and resolution
  localparam int EEM_ANGLE_W = 16;
  localparam int EEM_PPR_FIXED = 1024;
  localparam int EEM_PPR_MIN_LOG2 = 7;
  localparam int EEM_PPR_MAX_LOG2 = 14;
  localparam logic [3:0] EEM_PPR_LOG2_FIXED = 4'hA;
  // =========================================================
  // Speed and timing
  localparam int EEM_CLK_MHZ = 100;
  localparam int EEM_MAX_RPM_FIXED = 10000;
  // Least edge spacing the output stage guarantees, in ns
  localparam int EEM_EDGE_GAP_NS = 100;
  localparam int EEM_EDGE_GAP_CYC = (EEM_EDGE_GAP_NS * EEM_CLK_MHZ + 999) / 1000;
  // Index widths, in ns
  localparam int EEM_IDX_SHORT_NS = 1000;
  localparam int EEM_IDX_LONG_NS = 10000;
  localparam int EEM_IDX_XLONG_NS = 100000;
  localparam int EEM_IDX_SHORT_CYC = (EEM_IDX_SHORT_NS * EEM_CLK_MHZ + 999) / 1000;
  localparam int EEM_IDX_LONG_CYC = (EEM_IDX_LONG_NS * EEM_CLK_MHZ + 999) / 1000;
  localparam int EEM_IDX_XLONG_CYC = (EEM_IDX_XLONG_NS * EEM_CLK_MHZ + 999) / 1000;
  localparam int EEM_IDX_CNT_W = 14;
  // =========================================================
  // Index width selection codes
  typedef enum logic [1:0] {
    index_width_short = 2'h0,
    index_width_long = 2'h1,
    index_width_extra_long = 2'h2
  } eem_idx_sel_t;
endpackage : eem_pkg

//--- eem_step_gen.sv
// Quadrature step generator: walks an output count toward a target count.
// Assumes target changes slowly relative to the edge gap.
`timescale 1ns/1ns
`default_nettype none
module eem_step_gen
  import eem_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int GAP_CYC = EEM_EDGE_GAP_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [CNT_W-1:0] target,
  output logic [CNT_W-1:0] count,
  output logic step_up,
  output logic step_dn
);
  logic [7:0] gap;
  logic [CNT_W-1:0] diff;

  assign diff = target - count;

  // =========================================================
  // Stepping with pacing; shortest path around the circle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      gap <= 8'h00;
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end else begin
      step_up <= 1'b0;
      step_dn <= 1'b0;
      if (gap != 8'h00) begin
        gap <= gap - 8'h01;
      end else if (diff != '0) begin
        gap <= 8'(GAP_CYC - 1);
        if (!diff[CNT_W-1]) begin
          count <= count + 1'b1;
          step_up <= 1'b1;
        end else begin
          count <= count - 1'b1;
          step_dn <= 1'b1;
        end
      end
    end
  end
endmodule : eem_step_gen
`default_nettype wire

//--- eem_encoder_emulation_output.sv
// Encoder emulation output: rotor angle to A/B/index and complements.
// Assumes angle is a synchronous, full-circle unsigned word from the resolver.
`timescale 1ns/1ns
`default_nettype none
module eem_encoder_emulation_output
  import eem_pkg::*;
#(
  parameter bit CONFIGURABLE = 1'b0,
  parameter int ANGLE_W = EEM_ANGLE_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [ANGLE_W-1:0] rotor_angle,
  input wire logic [3:0] ppr_log2,
  input wire logic [1:0] index_width_select,
  output logic enc_a,
  output logic enc_a_n,
  output logic enc_b,
  output logic enc_b_n,
  output logic enc_idx,
  output logic enc_idx_n,
  output logic ppr_invalid
);
  localparam int CNT_W = EEM_PPR_MAX_LOG2 + 2;

  logic [3:0] eff_log2;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] scaled;
  logic [CNT_W-1:0] delta;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] cnt_mask;
  logic step_up;
  logic step_dn;
  logic idx_hit;
  logic [EEM_IDX_CNT_W-1:0] idx_cnt;
  logic [EEM_IDX_CNT_W-1:0] idx_len;
  logic next_a;
  logic next_b;

  // Legal resolution check, shared by decode and status
  function automatic logic eem_ppr_ok(input logic [3:0] l2);
    eem_ppr_ok = (l2 >= 4'(EEM_PPR_MIN_LOG2)) && (l2 <= 4'(EEM_PPR_MAX_LOG2));
  endfunction : eem_ppr_ok

  // =========================================================
  // Resolution selection
  // fixed count, or ppr_log2 when configurable and legal
  always_comb begin
    if (!CONFIGURABLE) begin
      eff_log2 = EEM_PPR_LOG2_FIXED;
    end else if (eem_ppr_ok(ppr_log2)) begin
      eff_log2 = ppr_log2;
    end else begin
      // Out of range falls back to the fixed count rather than stopping
      eff_log2 = EEM_PPR_LOG2_FIXED;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ppr_invalid <= 1'b0;
    end else begin
      ppr_invalid <= CONFIGURABLE && !eem_ppr_ok(ppr_log2);
    end
  end

  // =========================================================
  // Angle to quarter-step count (four edges per pulse)
  // angle conversion
  // Count runs free; target is count plus the short-way offset, so a turn wraps cleanly
  always_comb begin
    logic [31:0] wide;
    wide = 32'(rotor_angle) << (5'(eff_log2) + 5'h02);
    wide = wide >> ANGLE_W;
    cnt_mask = CNT_W'((32'h1 << (5'(eff_log2) + 5'h02)) - 32'h1);
    scaled = CNT_W'(wide) & cnt_mask;
    delta = (scaled - count) & cnt_mask;
    if (delta[eff_log2 + 4'h1]) begin
      delta = delta | ~cnt_mask;
    end
    target = count + delta;
  end

  // rate bound
  // Edge gap caps the output rate, so top speed scales inversely with resolution
  eem_step_gen #(
    .CNT_W(CNT_W),
    .GAP_CYC(EEM_EDGE_GAP_CYC)
  ) u_step (
    .mclk(mclk),
    .rst_b(rst_b),
    .target(target),
    .count(count),
    .step_up(step_up),
    .step_dn(step_dn)
  );

  // =========================================================
  // Quadrature decode of the count
  // ninety degree offset
  always_comb begin
    next_a = count[1];
    next_b = count[1] ^ count[0];
  end

  assign idx_hit = (step_up || step_dn) && ((count & cnt_mask) == '0);

  always_comb begin
    case (index_width_select)
      index_width_long: idx_len = EEM_IDX_CNT_W'(EEM_IDX_LONG_CYC);
      index_width_extra_long: idx_len = EEM_IDX_CNT_W'(EEM_IDX_XLONG_CYC);
      default: idx_len = EEM_IDX_CNT_W'(EEM_IDX_SHORT_CYC);
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idx_cnt <= '0;
    end else if (idx_hit) begin
      idx_cnt <= idx_len;
    end else if (idx_cnt != '0) begin
      idx_cnt <= idx_cnt - 1'b1;
    end
  end

  // =========================================================
  // Output registers
  // complementary pairs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      enc_a <= 1'b0;
      enc_a_n <= 1'b1;
      enc_b <= 1'b0;
      enc_b_n <= 1'b1;
      enc_idx <= 1'b0;
      enc_idx_n <= 1'b1;
    end else begin
      enc_a <= next_a;
      enc_a_n <= !next_a;
      enc_b <= next_b;
      enc_b_n <= !next_b;
      enc_idx <= idx_hit || (idx_cnt > 1);
      enc_idx_n <= !(idx_hit || (idx_cnt > 1));
    end
  end
endmodule : eem_encoder_emulation_output
`default_nettype wire

//--- eem_asserts.sv
// Checker for the encoder emulation outputs.
// Assumes one mclk domain, rst_b active low.
`timescale 1ns/1ns
`default_nettype none
module eem_asserts #(
  parameter bit CONFIGURABLE = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic enc_a,
  input wire logic enc_a_n,
  input wire logic enc_b,
  input wire logic enc_b_n,
  input wire logic enc_idx,
  input wire logic enc_idx_n,
  input wire logic ppr_invalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // =============================
  // Output relations
  a_a_pair: assert property (enc_a_n == !enc_a)
    else $error("enc_a_n wrong");
  a_b_pair: assert property (enc_b_n == !enc_b)
    else $error("enc_b_n wrong");
  a_idx_pair: assert property (enc_idx_n == !enc_idx)
    else $error("enc_idx_n wrong");
  a_one_channel: assert property ($changed(enc_a) |-> $stable(enc_b))
    else $error("A and B moved together");
  a_edge_gap: assert property (($changed(enc_a) || $changed(enc_b))
    |=> ($stable(enc_a) && $stable(enc_b))[*8]) else $error("edges too close");
  a_idx_hold: assert property ($rose(enc_idx) |=> enc_idx[*8])
    else $error("index too short");
  a_idx_zero: assert property ($rose(enc_idx) |-> !enc_a && !enc_b)
    else $error("index off zero");
  a_fixed_flag: assert property (!CONFIGURABLE |-> !ppr_invalid)
    else $error("flag in fixed variant");
  c_a_rise: cover property ($rose(enc_a));
  c_idx_rise: cover property ($rose(enc_idx));
  c_idx_fall: cover property ($fell(enc_idx));
endmodule : eem_asserts
bind eem_encoder_emulation_output eem_asserts #(.CONFIGURABLE(CONFIGURABLE)) u_asserts (
  .mclk(mclk), .rst_b(rst_b), .enc_a(enc_a), .enc_a_n(enc_a_n), .enc_b(enc_b),
  .enc_b_n(enc_b_n), .enc_idx(enc_idx), .enc_idx_n(enc_idx_n), .ppr_invalid(ppr_invalid));
`default_nettype wire

//--- eem_ctrl_model.sv
// Positioning controller model: counts quarter steps and index pulses.
// Assumes encoder lines already synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module eem_ctrl_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic a,
  input wire logic b,
  input wire logic idx,
  output var int pos,
  output var int idx_cnt,
  output var int idx_len
);
  logic [1:0] q_d;
  logic idx_d;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_d <= 2'h0;
      idx_d <= 1'b0;
      pos <= 0;
      idx_cnt <= 0;
      idx_len <= 0;
    end else begin
      q_d <= {a, a ^ b};
      idx_d <= idx;
      if ({a, a ^ b} - q_d == 2'h1) begin
        pos <= pos + 1;
      end else if ({a, a ^ b} - q_d == 2'h3) begin
        pos <= pos - 1;
      end
      if (idx && !idx_d) begin
        idx_cnt <= idx_cnt + 1;
      end
      if (idx) begin
        idx_len <= idx_d ? idx_len + 1 : 1;
      end
    end
  end
endmodule : eem_ctrl_model
`default_nettype wire

//--- eem_encoder_emulation_output_test.sv
// Testbench for the fixed and configurable variants of the encoder emulation.
// Assumes the controller model on the encoder lines.
`timescale 1ns/1ns
`default_nettype none
module eem_encoder_emulation_output_test;
  import eem_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] angle = 16'h0000;
  logic [1:0] wsel = 2'h0;
  logic [3:0] cfg_log2 = 4'hA;
  logic cfg_a, cfg_b, cfg_inv;
  logic enc_a, enc_a_n, enc_b, enc_b_n, enc_idx, enc_idx_n;
  int pos, idx_cnt, idx_len, n_fail, checks_done, c0;
  int wid [3] = '{EEM_IDX_SHORT_CYC, EEM_IDX_LONG_CYC, EEM_IDX_XLONG_CYC};
  always #5 mclk = ~mclk;
  eem_encoder_emulation_output #(.CONFIGURABLE(1'b0)) u_dut (.mclk(mclk), .rst_b(rst_b),
    .rotor_angle(angle), .ppr_log2(EEM_PPR_LOG2_FIXED), .index_width_select(wsel),
    .enc_a(enc_a), .enc_a_n(enc_a_n), .enc_b(enc_b), .enc_b_n(enc_b_n), .enc_idx(enc_idx),
    .enc_idx_n(enc_idx_n), .ppr_invalid());
  eem_encoder_emulation_output #(.CONFIGURABLE(1'b1)) u_dut_cfg (.mclk(mclk), .rst_b(rst_b),
    .rotor_angle(angle), .ppr_log2(cfg_log2), .index_width_select(wsel),
    .enc_a(cfg_a), .enc_a_n(), .enc_b(cfg_b), .enc_b_n(), .enc_idx(),
    .enc_idx_n(), .ppr_invalid(cfg_inv));
  eem_ctrl_model u_ctrl (.mclk(mclk), .rst_b(rst_b), .a(enc_a), .b(enc_b), .idx(enc_idx),
    .pos(pos), .idx_cnt(idx_cnt), .idx_len(idx_len));
  task check(input bit ok);
    checks_done++;
    if (!ok) begin
      n_fail++;
      $display("Error at %0t: output mismatch", $time);
    end
  endtask : check
  // Steps are rate bound, so the wait follows the edge gap
  task move(input logic [15:0] ang, input int steps);
    @(negedge mclk) angle = ang;
    repeat (steps * EEM_EDGE_GAP_CYC + 20) @(negedge mclk);
  endtask : move
  task t_cfg;
    @(negedge mclk) cfg_log2 = 4'h6;
    repeat (3) @(negedge mclk);
    check(cfg_inv === 1'b1);
    @(negedge mclk) cfg_log2 = 4'hE;
    move(16'h0003, 3);
    check(cfg_inv === 1'b0 && cfg_a === 1'b1 && cfg_b === 1'b0);
    move(16'h0000, 3);
    @(negedge mclk) cfg_log2 = 4'hA;
    repeat (3) @(negedge mclk);
    check(cfg_a === 1'b0 && cfg_b === 1'b0 && enc_a === 1'b0);
  endtask : t_cfg
  task t_walk;
    move(16'h0100, 16);
    check(pos == 16 && enc_a === 1'b0 && enc_b === 1'b0);
    move(16'h0090, 7);
    check(pos == 9 && enc_a === 1'b0 && enc_b === 1'b1);
  endtask : t_walk
  task t_turn;
    c0 = idx_cnt;
    for (int i = 0; i < 16; i++) begin
      move(angle + 16'h1000, 256);
    end
    check(pos == 9 + 4096 && idx_cnt == c0 + 1);
  endtask : t_turn
  task t_width;
    for (int s = 0; s < 3; s++) begin
      c0 = idx_cnt;
      @(negedge mclk) wsel = 2'(s);
      move(s[0] ? 16'h0090 : 16'hFF90, 16);
      repeat (wid[s] + 20) @(negedge mclk);
      check(idx_len == wid[s] && idx_cnt == c0 + 1);
    end
  endtask : t_width
  task print_verdict;
    $display("checks %0d, errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    t_cfg();
    t_walk();
    t_turn();
    t_width();
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
endmodule : eem_encoder_emulation_output_test
`default_nettype wire
